// ===== hdl/acc_ctrl.sv
// conversion sequencer with wishbone register slave
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
module acc_ctrl
    import acc_pkg::*;
#(
    parameter int RES_W    = 10,
    parameter int SYNC_CYC = TRIG_SYNC_CYC
) (
    // clock, reset, clock enable
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // auto-trigger sources, same clock
    input  wire logic [6:0]       trig_src_i,
    // analog core
    input  wire logic [RES_W-1:0] core_result_i,
    output acc_core_t             core_o
);

    if (RES_W < 9 || RES_W > 16) begin : g_bad_res
        $error("result width must be 9 to 16");
    end
    if (SYNC_CYC < 1 || SYNC_CYC > 7) begin : g_bad_sync
        $error("trigger sync cycles must be 1 to 7");
    end

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_WAIT = 4'b0010,
        S_SYNC = 4'b0100,
        S_CONV = 4'b1000
    } acc_state_t;

    localparam logic [2:0] SYNC_LAST = 3'(SYNC_CYC - 1);

    // divide factor: codes 0 and 1 both give 2
    function automatic logic [7:0] presc_div(input logic [PS_W-1:0] ps);
        presc_div = (ps == 3'h0) ? 8'h02 : (8'h01 << ps);
    endfunction

    // software registers
    logic                  en_r;
    logic                  auto_r;
    logic [PS_W-1:0]       ps_r;
    logic [TS_W-1:0]       ts_r;
    logic [REF_W-1:0]      ref_r;
    logic                  ladj_r;
    logic [CH_W-1:0]       ch_r;
    logic                  pwr_red_r;
    // internal state
    acc_state_t            state_r;
    logic [5:0]            hc_r;
    logic [2:0]            sync_r;
    logic                  kind_auto_r;
    logic                  first_r;
    logic                  en_prev_r;
    logic [7:0]            presc_r;
    logic                  flag_r;
    logic                  lock_r;
    logic [15:0]           res_r;
    logic [REF_W-1:0]      ref_buf_r;
    logic [CH_W-1:0]       ch_buf_r;
    logic                  trig_cur_r;
    logic                  trig_prev_r;
    logic [RES_W-1:0]      core_meta_r;
    logic [RES_W-1:0]      core_res_r;
    logic                  ack_r;
    logic [31:0]           dat_r;
    logic                  sh_r;

    logic                  en_eff;
    logic [7:0]            div;
    logic                  rise_t;
    logic                  fall_t;
    logic                  half_t;
    acc_lim_t              lim;
    logic [5:0]            hc_inc;
    logic                  done_p;
    logic                  sh_p;
    logic                  last_cyc;
    logic                  free_run;
    logic                  sync_go;
    logic                  trig_sel;
    logic                  trig_edge;
    logic                  trig_ok;
    logic                  busy;
    logic                  bus_req;
    logic                  wr;
    logic                  rd;
    logic                  start_wr;
    logic [15:0]           res_adj;
    logic [31:0]           rd_mux;

    // power gate
    // power reduction overrides the enable bit
    assign en_eff   = en_r & ~pwr_red_r;
    assign div      = presc_div(ps_r);
    assign rise_t   = en_eff && (presc_r == div - 8'h01);
    assign fall_t   = en_eff && (presc_r == (div >> 1) - 8'h01);
    assign half_t   = rise_t | fall_t;
    assign lim      = conv_limits(first_r, kind_auto_r);
    assign hc_inc   = hc_r + 6'h01;
    assign busy     = (state_r != S_IDLE);
    assign free_run = auto_r && (ts_r == TS_FREE_RUN);
    assign sync_go  = ce_i && en_eff && (state_r == S_SYNC)
                      && (sync_r == SYNC_LAST);
    assign done_p   = ce_i && en_eff && (state_r == S_CONV) && half_t
                      && (hc_inc == lim.done);
    assign sh_p     = ce_i && en_eff && (state_r == S_CONV) && half_t
                      && (hc_inc == lim.sh);
    assign last_cyc = (hc_r + 6'h02 >= lim.done);

    // wishbone decode; side effects only on the accepted cycle
    assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_r & ce_i;
    assign wr       = bus_req & wb_we_i & wb_sel_i[0];
    assign rd       = bus_req & ~wb_we_i;
    // start may arrive in the same write that sets enable
    assign start_wr = wr && (wb_adr_i == ADR_CTRL_A)
                      && wb_dat_i[BIT_START] && wb_dat_i[BIT_ENABLE]
                      && !pwr_red_r;

    // trigger sampling
    // source 0 is the own flag; handled as free running
    assign trig_sel  = (ts_r == TS_FREE_RUN) ? 1'b0
                                              : trig_src_i[ts_r - 3'h1];
    assign trig_edge = trig_cur_r & ~trig_prev_r;
    assign trig_ok   = auto_r && trig_edge && !busy;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_cur_r  <= 1'b0;
            trig_prev_r <= 1'b0;
        end else if (ce_i) begin
            trig_cur_r  <= trig_sel;
            trig_prev_r <= trig_cur_r;
        end
    end

    // analog result crosses in through two flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_meta_r <= '0;
            core_res_r  <= '0;
        end else if (ce_i) begin
            core_meta_r <= core_result_i;
            core_res_r  <= core_meta_r;
        end
    end

    // software control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r      <= RST_CTRL_A[BIT_ENABLE];
            auto_r    <= RST_CTRL_A[BIT_AUTO];
            ps_r      <= RST_CTRL_A[PS_LSB +: PS_W];
            ts_r      <= RST_CTRL_B[TS_LSB +: TS_W];
            ref_r     <= RST_CHSEL[REF_LSB +: REF_W];
            ladj_r    <= RST_CHSEL[BIT_LADJ];
            ch_r      <= RST_CHSEL[CH_LSB +: CH_W];
            pwr_red_r <= RST_PWRRED;
        end else if (wr) begin
            case (wb_adr_i)
                ADR_CTRL_A: begin
                    en_r   <= wb_dat_i[BIT_ENABLE];
                    auto_r <= wb_dat_i[BIT_AUTO];
                    ps_r   <= wb_dat_i[PS_LSB +: PS_W];
                end
                ADR_CTRL_B: ts_r <= wb_dat_i[TS_LSB +: TS_W];
                ADR_CHSEL: begin
                    ref_r  <= wb_dat_i[REF_LSB +: REF_W];
                    ladj_r <= wb_dat_i[BIT_LADJ];
                    ch_r   <= wb_dat_i[CH_LSB +: CH_W];
                end
                ADR_PWR: pwr_red_r <= wb_dat_i[BIT_PWRRED];
                default: ;
            endcase
        end
    end

    // trigger restarts prescaler for fixed latency
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_r <= 8'h00;
        end else if (ce_i) begin
            if (!en_eff || sync_go || rise_t) begin
                presc_r <= 8'h00;
            end else begin
                presc_r <= presc_r + 8'h01;
            end
        end
    end

    // first conversion after enable gets the long timing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_prev_r <= 1'b0;
            first_r   <= 1'b0;
        end else if (ce_i) begin
            en_prev_r <= en_eff;
            if (en_eff && !en_prev_r) begin
                first_r <= 1'b1;
            end else if (done_p) begin
                first_r <= 1'b0;
            end
        end
    end

    // conversion sequencer; dropping enable aborts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r     <= S_IDLE;
            hc_r        <= 6'h00;
            sync_r      <= 3'h0;
            kind_auto_r <= 1'b0;
        end else if (ce_i) begin
            if (!en_eff && !start_wr) begin
                state_r <= S_IDLE;
            end else begin
                case (state_r)
                    S_IDLE: begin
                        if (start_wr) begin
                            state_r <= S_WAIT;
                        end else if (trig_ok) begin
                            state_r <= S_SYNC;
                            sync_r  <= 3'h0;
                        end
                    end
                    S_WAIT: begin
                        if (rise_t) begin
                            state_r     <= S_CONV;
                            hc_r        <= 6'h00;
                            kind_auto_r <= 1'b0;
                        end
                    end
                    S_SYNC: begin
                        if (sync_r == SYNC_LAST) begin
                            state_r     <= S_CONV;
                            hc_r        <= 6'h00;
                            kind_auto_r <= 1'b1;
                        end else begin
                            sync_r <= sync_r + 3'h1;
                        end
                    end
                    S_CONV: begin
                        if (half_t) begin
                            if (hc_inc == lim.done) begin
                                if (free_run) begin
                                    hc_r        <= 6'h00;
                                    kind_auto_r <= 1'b0;
                                end else begin
                                    state_r <= S_IDLE;
                                end
                            end else begin
                                hc_r <= hc_inc;
                            end
                        end
                    end
                    default: state_r <= S_IDLE;
                endcase
            end
        end
    end

    // selection buffer
    // locks while converting so the sampled input stays put
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_buf_r <= '0;
            ch_buf_r  <= '0;
        end else if (ce_i && (state_r != S_CONV || last_cyc)) begin
            ref_buf_r <= ref_r;
            ch_buf_r  <= ch_r;
        end
    end

    // done flag
    // set beats a same-cycle write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_r <= 1'b0;
        end else if (done_p) begin
            flag_r <= 1'b1;
        end else if (wr && wb_adr_i == ADR_CTRL_A
                     && wb_dat_i[BIT_DONE]) begin
            flag_r <= 1'b0;
        end
    end

    assign res_adj = ladj_r ? {core_res_r, (16 - RES_W)'(0)}
                            : {(16 - RES_W)'(0), core_res_r};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_r <= 1'b0;
            res_r  <= 16'h0000;
        end else if (ce_i) begin
            if (rd && wb_adr_i == ADR_RES_LO) begin
                lock_r <= 1'b1;
            end else if (rd && wb_adr_i == ADR_RES_HI) begin
                lock_r <= 1'b0;
            end
            if (done_p && !lock_r) begin
                res_r <= res_adj;
            end
        end
    end

    // readback; unmapped addresses read zero and still ack
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            ADR_CTRL_A: begin
                rd_mux[BIT_ENABLE]       = en_r;
                rd_mux[BIT_START]        = busy;
                rd_mux[BIT_AUTO]         = auto_r;
                rd_mux[BIT_DONE]         = flag_r;
                rd_mux[PS_LSB +: PS_W]   = ps_r;
            end
            ADR_CTRL_B: rd_mux[TS_LSB +: TS_W] = ts_r;
            ADR_CHSEL: begin
                rd_mux[REF_LSB +: REF_W] = ref_r;
                rd_mux[BIT_LADJ]         = ladj_r;
                rd_mux[CH_LSB +: CH_W]   = ch_r;
            end
            ADR_RES_LO: rd_mux[7:0]      = res_r[7:0];
            ADR_RES_HI: rd_mux[7:0]      = res_r[15:8];
            ADR_PWR:    rd_mux[BIT_PWRRED] = pwr_red_r;
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_r <= bus_req;
            if (rd) begin
                dat_r <= rd_mux;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh_r <= 1'b0;
        end else if (ce_i) begin
            sh_r <= sh_p;
        end
    end

    // core drive
    // selections reach the core only while enabled
    always_comb begin
        core_o.analog_en   = en_eff;
        core_o.sample_hold = sh_r;
        core_o.busy        = busy;
        core_o.ref_sel     = en_eff ? ref_buf_r : '0;
        core_o.chan        = en_eff ? ch_buf_r : '0;
    end

    // checks
    a_flag_on_done: assert property (
        @(posedge clk_i) disable iff (rst_i)
        done_p |=> flag_r)
        else $error("done flag not set at completion");

    a_start_clears: assert property (
        @(posedge clk_i) disable iff (rst_i)
        done_p && !free_run |=> !busy && !core_o.busy)
        else $error("start bit not cleared at completion");

    a_free_restart: assert property (
        @(posedge clk_i) disable iff (rst_i)
        done_p && free_run |=> state_r == S_CONV && hc_r == 6'h00)
        else $error("free running did not restart");

    a_lock_holds: assert property (
        @(posedge clk_i) disable iff (rst_i)
        done_p && lock_r |=> $stable(res_r))
        else $error("locked result was overwritten");

    a_unlock_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd && wb_adr_i == ADR_RES_HI |=> !lock_r)
        else $error("high byte read did not unlock");

    a_len_normal: assert property (
        @(posedge clk_i) disable iff (rst_i)
        done_p && !first_r && !kind_auto_r |-> hc_r == 6'h19)
        else $error("normal conversion not 13 cycles");

    a_len_first: assert property (
        @(posedge clk_i) disable iff (rst_i)
        done_p && first_r |-> hc_r == 6'h31)
        else $error("first conversion not 25 cycles");

    a_sh_auto: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sh_p && kind_auto_r && !first_r |-> hc_r == 6'h03)
        else $error("auto sample not at 2 cycles");

    a_presc_reset: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && !en_eff && !start_wr
        |=> presc_r == 8'h00 && state_r == S_IDLE)
        else $error("prescaler runs while disabled");

    a_chan_locked: assert property (
        @(posedge clk_i) disable iff (rst_i)
        state_r == S_CONV && !last_cyc && $stable(state_r)
        && !$past(last_cyc)
        |-> $stable(ch_buf_r))
        else $error("channel changed mid conversion");

    a_edge_ignored: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && state_r == S_CONV && trig_edge && !done_p
        |=> state_r == S_CONV)
        else $error("trigger edge disturbed a conversion");

endmodule

// ===== hdl/acc_pkg.sv
// Functional notes
// - selections act only while converter enabled
// - result right-justified, or left when selected
// - low byte read freezes both result bytes
// - high byte read releases the freeze
// - done flag sets even for discarded results
// - start bit begins conversion, reads busy
// - channel change waits for running conversion
// - trigger rising edge resets prescaler, starts
// - held or mid-conversion trigger edges ignored
// - trigger flag must fall before retriggering
// - own done flag source means free running
// - start bit works with auto trigger on
// - prescaler runs while enabled, else reset
// - single start waits next converter rising edge
// - conversion 13 cycles, first one 25
// - sample-hold at 1.5, first at 13.5
// - completion stores result, sets flag, clears start
// - auto: sample at 2, length 13.5
// - free running restarts at once, start stays
// - channel field picks pin, ground, bandgap
// - selections latched at start, track last cycle
package acc_pkg;

    // register byte offsets on the wishbone slave
    localparam logic [7:0] ADR_CTRL_A   = 8'h00;
    localparam logic [7:0] ADR_CTRL_B   = 8'h04;
    localparam logic [7:0] ADR_CHSEL    = 8'h08;
    localparam logic [7:0] ADR_RES_LO   = 8'h0C;
    localparam logic [7:0] ADR_RES_HI   = 8'h10;
    localparam logic [7:0] ADR_PWR      = 8'h14;

    // converter_control_status_a fields
    localparam int BIT_ENABLE = 7;
    localparam int BIT_START  = 6;
    localparam int BIT_AUTO   = 5;
    localparam int BIT_DONE   = 4;
    localparam int PS_LSB     = 0;
    localparam int PS_W       = 3;
    // converter_control_status_b fields
    localparam int TS_LSB     = 0;
    localparam int TS_W       = 3;
    // channel_reference_select_reg fields
    localparam int REF_LSB    = 6;
    localparam int REF_W      = 2;
    localparam int BIT_LADJ   = 5;
    localparam int CH_LSB     = 0;
    localparam int CH_W       = 4;
    // power register field
    localparam int BIT_PWRRED = 0;

    // reset values
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    localparam logic [7:0] RST_CHSEL  = 8'h00;
    localparam logic       RST_PWRRED = 1'b0;

    // trigger select code that means free running
    localparam logic [TS_W-1:0] TS_FREE_RUN = 3'h0;

    // timing in converter clock half cycles
    localparam logic [5:0] SH_NORM_H    = 6'h03;
    localparam logic [5:0] DONE_NORM_H  = 6'h1A;
    localparam logic [5:0] SH_FIRST_H   = 6'h1B;
    localparam logic [5:0] DONE_FIRST_H = 6'h32;
    localparam logic [5:0] SH_AUTO_H    = 6'h04;
    localparam logic [5:0] DONE_AUTO_H  = 6'h1B;
    // cpu cycles spent synchronising a trigger
    localparam int TRIG_SYNC_CYC = 3;

    typedef struct packed {
        logic [5:0] sh;
        logic [5:0] done;
    } acc_lim_t;

    typedef struct packed {
        logic             analog_en;
        logic             sample_hold;
        logic             busy;
        logic [REF_W-1:0] ref_sel;
        logic [CH_W-1:0]  chan;
    } acc_core_t;

    // first conversion wins over auto-trigger timing
    function automatic acc_lim_t conv_limits(input logic first,
                                             input logic auto_trig);
        acc_lim_t l;
        if (first) begin
            l.sh   = SH_FIRST_H;
            l.done = DONE_FIRST_H;
        end else if (auto_trig) begin
            l.sh   = SH_AUTO_H;
            l.done = DONE_AUTO_H;
        end else begin
            l.sh   = SH_NORM_H;
            l.done = DONE_NORM_H;
        end
        return l;
    endfunction

endpackage

// ===== verif/acc_core_model.sv
// stand-in for the analog core: holds a code built from the selection
module acc_core_model
    import acc_pkg::*;
(
    // clock, reset
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    // sequencer side
    input  wire acc_core_t core_i,
    output logic [9:0]     result_o
);
    logic [9:0] held_r;

    // code taken at the hold pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            held_r <= 10'h000;
        end else if (core_i.sample_hold) begin
            held_r <= {core_i.chan, core_i.ref_sel, 4'hA};
        end
    end

    // idle core output is garbage, never the last code
    assign result_o = core_i.busy ? held_r : ~held_r;
endmodule

// ===== verif/testbench.sv
// bench for the conversion sequencer and its register slave
module testbench
    import acc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] dat   = 32'h0000_0000;
    logic [6:0]  trig  = 7'h00;
    logic [31:0] rdat;
    logic        ack;
    logic [9:0]  res;
    acc_core_t   core;
    logic        busy_q = 1'b0;
    logic [7:0]  q;
    int          errors = 0;
    int          n_tests = 0;
    int          cyc_n = 0;
    int          n_conv = 0;

    always #12.5 clk_i = ~clk_i;

    acc_ctrl acc_ctrl_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
        .wb_dat_o(rdat), .wb_ack_o(ack), .trig_src_i(trig),
        .core_result_i(res), .core_o(core));

    acc_core_model acc_core_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .core_i(core), .result_o(res));

    task automatic wrap_up();
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // conversion counter and hang guard
    always @(posedge clk_i) begin
        busy_q <= core.busy;
        if (core.busy === 1'b1 && busy_q !== 1'b1) n_conv <= n_conv + 1;
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // classic single cycle; read data taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
        @(posedge clk_i);
        req <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h0000_00, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat[7:0];
        req <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wait_conv(output int n);
        n = 0;
        repeat (300) if (core.busy !== 1'b1) @(posedge clk_i);
        while (core.busy === 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    function automatic logic [9:0] exp_r(input logic [3:0] ch,
                                         input logic [1:0] rf);
        return {ch, rf, 4'hA};
    endfunction

    task automatic rd_res(input logic [9:0] r, input logic la);
        wb(1'b0, ADR_RES_LO, 8'h00);
        chk(q, la ? {r[1:0], 6'h00} : r[7:0]);
        wb(1'b0, ADR_RES_HI, 8'h00);
        chk(q, la ? r[9:2] : {6'h00, r[9:8]});
    endtask

    // every offset plus one unmapped reads zero out of reset
    task automatic t_reset();
        for (int a = 0; a <= 'h18; a += 4) begin
            wb(1'b0, 8'(a), 8'h00);
            chk(q, 8'h00);
        end
    endtask

    task automatic t_first();
        int n;
        // short divisor for run time; resolution is not modelled
        wb(1'b1, ADR_PWR, 8'h00);
        wb(1'b1, ADR_CHSEL, 8'h43);
        chk(8'({core.ref_sel, core.chan}), 8'h00);
        wb(1'b1, ADR_CTRL_A, 8'hC0);
        chk(8'(core.analog_en), 8'h01);
        wait_conv(n);
        chk(8'(n >= 49 && n <= 53), 8'h01);
        wb(1'b0, ADR_CTRL_A, 8'h00);
        chk(8'(q[BIT_DONE]), 8'h01);
        chk(8'(q[BIT_START]), 8'h00);
        rd_res(exp_r(4'h3, 2'h1), 1'b0);
    endtask

    task automatic t_lock();
        int n;
        wb(1'b1, ADR_CHSEL, 8'h65);
        wb(1'b1, ADR_CTRL_A, 8'hD0);
        wb(1'b0, ADR_CTRL_A, 8'h00);
        chk(8'(q[BIT_START]), 8'h01);
        wb(1'b1, ADR_CHSEL, 8'h66);
        wait_conv(n);
        chk(8'(n >= 21 && n <= 29), 8'h01);
        rd_res(exp_r(4'h5, 2'h1), 1'b1);
        wb(1'b0, ADR_RES_LO, 8'h00);
        wb(1'b1, ADR_CTRL_A, 8'hD0);
        wait_conv(n);
        wb(1'b0, ADR_CTRL_A, 8'h00);
        chk(8'(q[BIT_DONE]), 8'h01);
        rd_res(exp_r(4'h5, 2'h1), 1'b1);
        wb(1'b1, ADR_CTRL_A, 8'hD0);
        wait_conv(n);
        rd_res(exp_r(4'h6, 2'h1), 1'b1);
    endtask

    task automatic t_auto();
        int n;
        int n0;
        wb(1'b1, ADR_CTRL_B, 8'h01);
        wb(1'b1, ADR_CTRL_A, 8'hB0);
        n0 = n_conv;
        trig <= 7'h01;
        wait_conv(n);
        repeat (80) @(posedge clk_i);
        chk(8'(n_conv - n0), 8'h01);
        // level must fall before the next edge
        trig <= 7'h00;
        @(posedge clk_i);
        trig <= 7'h01;
        repeat (12) @(posedge clk_i);
        trig <= 7'h00;
        @(posedge clk_i);
        trig <= 7'h01;
        wait_conv(n);
        repeat (80) @(posedge clk_i);
        chk(8'(n_conv - n0), 8'h02);
        trig <= 7'h00;
    endtask

    task automatic t_free();
        int k;
        k = 0;
        wb(1'b1, ADR_CTRL_B, 8'h00);
        wb(1'b1, ADR_CTRL_A, 8'hE0);
        repeat (100) begin
            @(posedge clk_i);
            if (core.busy !== 1'b1) k++;
        end
        chk(8'(k), 8'h00);
        wb(1'b0, ADR_CTRL_A, 8'h00);
        chk(8'(q[BIT_START]), 8'h01);
        chk(8'(q[BIT_DONE]), 8'h01);
        wb(1'b1, ADR_CTRL_A, 8'h00);
        @(posedge clk_i);
        chk(8'({core.analog_en, core.busy}), 8'h00);
        chk(8'({core.ref_sel, core.chan}), 8'h00);
        wb(1'b1, ADR_CTRL_A, 8'h80);
        wb(1'b1, ADR_PWR, 8'h01);
        chk(8'(core.analog_en), 8'h00);
        wb(1'b1, ADR_PWR, 8'h00);
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_first();
        t_lock();
        t_auto();
        t_free();
        wrap_up();
    end
endmodule
